/* eeprom_write_regs.vh */
// Operation
// - Write shifts in a 16-bit data word and stores it at the address
// - After last data bit of write, timed erase then program of that word
// - Status shown on data output when chip select returns high during a cycle
// - Data output low while programming still runs
// - Data output high once the word is written and device is ready
// - Write-all programs every word with the one supplied data value
// - Write-all cycle is self-timed, starting at the last data bit edge
// - A started cycle completes with no further serial clock edges
// - Write-all erases the whole array automatically before programming
// - Write-all executes only while programming is enabled
// - Start is first clock edge with chip select and serial input high; starts are dropped while busy
// - Instruction executes only after all its bits arrived, 25 clocks for writes
// - Power up disabled; writes ignored until program-enable executes
// - Data output goes high impedance on falling edge of chip select
`ifndef EEPROM_WRITE_REGS_VH
`define EEPROM_WRITE_REGS_VH
`define OP_WRITE 2'h1
`define OP_SPECIAL 2'h0
`define SUB_PROGRAM_ALL 2'h1
`define SUB_ENABLE 2'h3
`define SUB_DISABLE 2'h0
`define SUB_ERASE_ALL 2'h2
`define ADDR_BITS 6
`define DATA_BITS 16
`define SHORT_BITS 8
`define LONG_BITS 24
`define SHORT_LAST 5'h07
`define LONG_LAST 5'h17
`define T_ERASE_NS 1000
`define T_PROG_NS 1000
`define CLK_PERIOD_NS 5
`define ERASE_CYCLES ((`T_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES ((`T_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASED_WORD 16'hffff
`endif

/* word_memory.v */
`default_nettype none
module word_memory #(
  parameter AW = 6,
  parameter DW = 16
) (
  input wire clock, // System clock
  input wire we, // Write strobe
  input wire [AW-1:0] waddr, // Write address
  input wire [DW-1:0] wdata, // Write data
  input wire [AW-1:0] raddr, // Read address
  output reg [DW-1:0] rdata // Registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* eeprom_write.v */
`include "eeprom_write_regs.vh"
`default_nettype none
module eeprom_write #(
  parameter AW = `ADDR_BITS,
  parameter DW = `DATA_BITS,
  parameter ERASE_CYCLES = `ERASE_CYCLES,
  parameter PROG_CYCLES = `PROG_CYCLES
) (
  input wire clock, // 200 MHz system clock
  input wire resetn, // Async reset, active low
  input wire chip_select, // Serial chip select pin
  input wire serial_clock, // Serial clock pin
  input wire serial_in_line, // Serial data in pin
  output reg serial_out, // Serial data out value
  output reg serial_out_en, // High while driving data out
  output reg busy, // High during a timed cycle
  input wire [AW-1:0] peek_addr, // Array readback address
  output reg [DW-1:0] peek_data // Array readback data
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] cs_sync;
  reg [1:0] sk_sync;
  reg [1:0] di_sync;
  reg sk_last;
  reg cs_last;

  // Only the second stage of each pair feeds logic; edge detectors reset low like idle pins
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cs_sync <= 2'h0;
      sk_sync <= 2'h0;
      di_sync <= 2'h0;
      sk_last <= 1'b0;
      cs_last <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], chip_select};
      sk_sync <= {sk_sync[0], serial_clock};
      di_sync <= {di_sync[0], serial_in_line};
      sk_last <= sk_sync[1];
      cs_last <= cs_sync[1];
    end
  end

  wire cs = cs_sync[1];
  wire di = di_sync[1];
  wire sk_rise = sk_sync[1] & ~sk_last;
  wire cs_fall = cs_last & ~cs;
  wire cs_rise = cs & ~cs_last;


  // ****************************************
  // Instruction shifter
  // ****************************************
  localparam S_IDLE = 2'h0;
  localparam S_SHIFT = 2'h1;
  localparam S_DONE = 2'h2;
  reg [1:0] sstate;
  reg [4:0] count;
  reg [23:0] shreg;
  reg enabled;
  reg exec_write;
  reg exec_all;
  wire [23:0] next_shreg = {shreg[22:0], di};

  // Short decode: seven bits are held, the eighth arrives on this edge
  wire [1:0] op_short = shreg[6:5];
  wire [1:0] sub_short = shreg[4:3];
  wire is_special = (op_short == `OP_SPECIAL);
  wire is_enable = is_special && (sub_short == `SUB_ENABLE);
  wire is_disable = is_special && (sub_short == `SUB_DISABLE);
  wire is_long = (op_short == `OP_WRITE) || (is_special && (sub_short == `SUB_PROGRAM_ALL));

  // Long decode: 23 bits are held, the last data bit arrives on this edge
  wire [1:0] op_long = shreg[22:21];
  wire [1:0] sub_long = shreg[20:19];
  wire long_write = enabled && (op_long == `OP_WRITE);
  wire long_all = enabled && (op_long == `OP_SPECIAL) && (sub_long == `SUB_PROGRAM_ALL);
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sstate <= S_IDLE;
      count <= 5'h0;
      shreg <= 24'h0;
      enabled <= 1'b0;
      exec_write <= 1'b0;
      exec_all <= 1'b0;
    end else begin
      exec_write <= 1'b0;
      exec_all <= 1'b0;
      if (!cs) begin
        // Deselect holds the shifter in reset and drops a partial frame
        sstate <= S_IDLE;
        count <= 5'h0;
      end else if (sk_rise) begin
        case (sstate)
          S_IDLE: begin
            // Starts during a timed cycle are dropped so the array is not disturbed
            if (di && !busy) begin
              sstate <= S_SHIFT;
              count <= 5'h0;
            end
          end
          S_SHIFT: begin
            shreg <= next_shreg;
            count <= count + 5'h1;
            if (count == `SHORT_LAST) begin
              if (is_enable) begin
                enabled <= 1'b1;
                sstate <= S_DONE;
              end else if (is_disable) begin
                enabled <= 1'b0;
                sstate <= S_DONE;
              end else if (!is_long) begin
                // Erase and read frames are not handled here and are ignored
                sstate <= S_DONE;
              end
            end else if (count == `LONG_LAST) begin
              sstate <= S_DONE;
              exec_write <= long_write;
              exec_all <= long_all;
            end
          end

          S_DONE: begin
            // Further clocks are ignored until chip select drops
            sstate <= S_DONE;
          end
          default: begin
            sstate <= S_IDLE;
          end
        endcase
      end
    end
  end
  // ****************************************
  // Timed erase and program engine
  // ****************************************
  // Runs on the system clock only, so no serial clock is needed to finish
  localparam P_IDLE = 2'h0;
  localparam P_ERASE = 2'h1;
  localparam P_PROG = 2'h2;
  reg [1:0] pstate;
  // Wide timer so long program times need no width change
  reg [31:0] timer;
  reg all_mode;
  reg [AW-1:0] target;
  reg [DW-1:0] value;
  reg [AW-1:0] sweep;
  reg mem_we;
  reg [AW-1:0] mem_addr;
  reg [DW-1:0] mem_data;

  // Write-all is timed once per pass, then sweeps one word per clock
  wire sweep_last = (sweep == {AW{1'b1}});

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pstate <= P_IDLE;
      timer <= 32'h0;
      all_mode <= 1'b0;
      target <= {AW{1'b0}};
      value <= {DW{1'b0}};
      sweep <= {AW{1'b0}};
      busy <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= {AW{1'b0}};
      mem_data <= {DW{1'b0}};
    end else begin
      mem_we <= 1'b0;
      case (pstate)
        P_IDLE: begin
          // Target and value are latched so the shifter may be reused later
          if (exec_write || exec_all) begin
            pstate <= P_ERASE;
            all_mode <= exec_all;
            target <= shreg[AW+DW-1:DW];
            value <= shreg[DW-1:0];
            timer <= 32'h0;
            sweep <= {AW{1'b0}};
            busy <= 1'b1;
          end
        end

        // Erase pass leaves each word at the erased level before programming
        P_ERASE: begin
          if (timer >= ERASE_CYCLES - 1) begin
            mem_we <= 1'b1;
            mem_addr <= all_mode ? sweep : target;
            mem_data <= `ERASED_WORD;
            if (!all_mode || sweep_last) begin
              pstate <= P_PROG;
              timer <= 32'h0;
              sweep <= {AW{1'b0}};
            end else begin
              sweep <= sweep + {{(AW-1){1'b0}}, 1'b1};
            end
          end else begin
            timer <= timer + 32'h1;
          end
        end

        // Program pass reuses the timer; write-all sweeps from word 0 again
        P_PROG: begin
          if (timer >= PROG_CYCLES - 1) begin
            mem_we <= 1'b1;
            mem_addr <= all_mode ? sweep : target;
            mem_data <= value;
            if (!all_mode || sweep_last) begin
              pstate <= P_IDLE;
              busy <= 1'b0;
            end else begin
              sweep <= sweep + {{(AW-1){1'b0}}, 1'b1};
            end
          end else begin
            timer <= timer + 32'h1;
          end
        end

        default: begin
          pstate <= P_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Array
  // ****************************************
  wire [DW-1:0] mem_rdata;

  word_memory #(.AW(AW), .DW(DW)) array (
    .clock(clock),
    .we(mem_we),
    .waddr(mem_addr),
    .wdata(mem_data),
    .raddr(peek_addr),
    .rdata(mem_rdata)
  );

  // Extra stage so the readback port comes straight from a flop
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      peek_data <= {DW{1'b0}};
    end else begin
      peek_data <= mem_rdata;
    end
  end

  // ****************************************
  // Progress indication on data out
  // ****************************************
  // Status armed by a timed cycle; shown from the next chip select rise
  // Staying deselected for the whole cycle still shows ready once at the next select
  reg status_armed;
  wire cycle_start = exec_write | exec_all;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_armed <= 1'b0;
    end else if (cycle_start) begin
      status_armed <= 1'b1;
    end else if (cs_rise && status_armed && !busy) begin
      // Ready has now been shown once; later selects stay quiet
      status_armed <= 1'b0;
    end
  end

  // Drive enable: released as soon as chip select is seen low
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_out_en <= 1'b0;
    end else if (!cs || cs_fall) begin
      serial_out_en <= 1'b0;
    end else if (cs_rise && (status_armed || cycle_start)) begin
      serial_out_en <= 1'b1;
    end else if (serial_out_en && sk_rise && di && !busy) begin
      // A new start bit ends the status phase
      serial_out_en <= 1'b0;
    end
  end

  // Level lags busy by one clock, in step with the registered enable
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= ~busy;
    end
  end
endmodule
`default_nettype wire

/* eeprom_write_properties.sv */
`default_nettype none
module eeprom_write_properties #(parameter ERASE_CYCLES = 4, parameter PROG_CYCLES = 4) (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset
  input wire logic chip_select, // Select
  input wire logic serial_clock, // Link clock
  input wire logic serial_in_line, // Data in
  input wire logic serial_out, // Data out
  input wire logic serial_out_en, // Out enable
  input wire logic busy, // Timed cycle
  input wire logic [5:0] peek_addr, // Peek address
  input wire logic [15:0] peek_data // Peek data
);
  // ****
  // Busy length count
  // ****
  int n;
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      n <= 0;
    else
      n <= busy ? n + 1 : 0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_OUT_BUSY: assert property (serial_out_en && busy && $past(busy) |-> !serial_out)
    else $error("ready shown while busy");
  AST_OUT_READY: assert property (serial_out_en && $past(serial_out_en) && !busy &&
    !$past(busy) |-> serial_out) else $error("busy shown while ready");
  AST_HIZ_FALL: assert property ($fell(chip_select) |-> ##[1:4] !serial_out_en)
    else $error("data out still driven");
  AST_HIZ_HOLD: assert property (!chip_select && !serial_out_en |=> !serial_out_en)
    else $error("data out driven while deselected");
  AST_POLL: assert property ($rose(chip_select) && busy |-> ##[1:3] serial_out_en)
    else $error("no status on poll");
  AST_BUSY_MIN: assert property ($fell(busy) |-> n >= ERASE_CYCLES + PROG_CYCLES)
    else $error("timed cycle too short");
  AST_BUSY_MAX: assert property (n <= 64 * (ERASE_CYCLES + PROG_CYCLES + 2))
    else $error("timed cycle never ends");
  AST_START: assert property ($rose(busy) |-> chip_select && serial_clock)
    else $error("cycle began without last bit");
  cover property ($fell(busy));
  cover property (serial_out_en && busy);
  cover property (serial_out_en && serial_out);
endmodule
bind eeprom_write eeprom_write_properties #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)) u_props (.clock(clock), .resetn(resetn),
  .chip_select(chip_select), .serial_clock(serial_clock), .serial_in_line(serial_in_line),
  .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy),
  .peek_addr(peek_addr), .peek_data(peek_data));
`default_nettype wire

/* serial_host.sv */
`default_nettype none
module serial_host (
  input wire logic clock, // System clock
  output logic chip_select, // Select
  output logic serial_clock, // Link clock, still between frames
  output logic serial_in_line // Data to device
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Host link master
  // ****
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in_line = 1'b0;
  end
  task automatic ticks(input int k);
    repeat (k) @(posedge clock);
  endtask
  // MSB first, half period 80 ns; leading zeros precede start
  task automatic frame(input logic [31:0] b, input int k);
    @(posedge clock);
    chip_select <= 1'b1;
    for (int i = k - 1; i >= 0; i--) begin
      serial_in_line <= b[i];
      ticks(16);
      serial_clock <= 1'b1;
      ticks(16);
      serial_clock <= 1'b0;
    end
    serial_in_line <= ~serial_in_line;
  endtask
  task automatic deselect();
    @(posedge clock);
    chip_select <= 1'b0;
    ticks(60);
  endtask
  task automatic reselect();
    @(posedge clock);
    chip_select <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* eeprom_write_test.sv */
`default_nettype none
module eeprom_write_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
  logic clock, resetn;
  logic [5:0] peek_addr;
  wire chip_select, serial_clock, serial_in_line, serial_out, serial_out_en, busy;
  wire [15:0] peek_data;
  int miscompares = 0, cmp_count = 0;
  serial_host u_host (.clock(clock), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in_line(serial_in_line));
  eeprom_write #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) u_dut (.clock(clock), .resetn(resetn),
    .chip_select(chip_select), .serial_clock(serial_clock), .serial_in_line(serial_in_line),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy),
    .peek_addr(peek_addr), .peek_data(peek_data));
  // ****
  // Scenarios
  // ****
  task automatic ticks(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++)
      @(negedge clock);
  endtask
  task automatic peek(input logic [5:0] a, input logic [15:0] e);
    @(posedge clock);
    peek_addr <= a;
    ticks(3);
    `CHK(peek_data, e)
  endtask
  task automatic t_locked();
    u_host.frame({1'b1, 2'h1, 6'h2a, 16'h1234}, 25);
    ticks(1);
    `CHK(busy, 1'b0)
    u_host.deselect();
    u_host.frame(32'h130, 12);
    u_host.deselect();
  endtask
  task automatic t_all();
    u_host.frame({1'b1, 2'h0, 6'h10, 16'ha5c3}, 25);
    ticks(1);
    `CHK(busy, 1'b1)
    u_host.deselect();
    u_host.reselect();
    ticks(3);
    `CHK(serial_out_en, 1'b1)
    `CHK(serial_out, 1'b0)
    wait_ready();
    ticks(2);
    `CHK(serial_out, 1'b1)
    u_host.deselect();
    `CHK(serial_out_en, 1'b0)
    for (int a = 0; a < 64; a++)
      peek(a[5:0], 16'ha5c3);
  endtask
  task automatic t_word();
    u_host.frame({1'b1, 2'h1, 6'h2a, 15'h091a}, 24);
    ticks(1);
    `CHK(busy, 1'b0)
    u_host.deselect();
    u_host.frame({1'b1, 2'h1, 6'h2a, 16'h1234}, 25);
    ticks(1);
    `CHK(busy, 1'b1)
    wait_ready();
    `CHK(busy, 1'b0)
    u_host.deselect();
    peek(6'h2a, 16'h1234);
    peek(6'h29, 16'ha5c3);
  endtask
  task automatic t_off();
    u_host.frame(32'h100, 9);
    u_host.deselect();
    u_host.frame({1'b1, 2'h0, 6'h10, 16'h0f0f}, 25);
    ticks(1);
    `CHK(busy, 1'b0)
    u_host.deselect();
    peek(6'h03, 16'ha5c3);
  endtask
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200us;
    miscompares++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    peek_addr = 6'h00;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    ticks(4);
    t_locked();
    t_all();
    t_word();
    t_off();
    end_sim();
  end
endmodule
`default_nettype wire
